// >>> src/swd_pkg.sv
// constants, states and carrier types of the super i/o watchdog timer
package swd_pkg;

   // ****************************************************************
   // i/o port map and configuration indices
   // ****************************************************************
   localparam logic [15:0] INDEX_PORT = 16'h002e;
   localparam logic [15:0] DATA_PORT = 16'h002f;
   localparam logic [7:0] UNLOCK_KEY = 8'h87;
   localparam logic [7:0] IDX_LOGICAL_DEVICE_SELECT = 8'h07;
   localparam logic [7:0] IDX_WATCHDOG_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_TIME_BASE_SELECT = 8'hf5;
   localparam logic [7:0] IDX_TIMEOUT_COUNT = 8'hf6;
   localparam logic [7:0] LDN_WATCHDOG_TIMER = 8'h08;

   // ****************************************************************
   // field values and reset values
   // ****************************************************************
   localparam logic [7:0] ACTIVATE_ON = 8'h01;
   localparam logic [7:0] ACTIVATE_OFF = 8'h00;
   localparam int ACTIVATE_BIT = 0;
   localparam logic [7:0] TIME_BASE_SECOND = 8'h00;
   localparam logic [7:0] TIME_BASE_MINUTE = 8'h08;
   localparam int TIME_BASE_MINUTE_BIT = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] LOCKED_READ = 8'hff;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int SECOND_NS = 1000000000;
   localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
   localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3c;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      LOCK_CLOSED = 2'b00,
      LOCK_ONE_KEY = 2'b01,
      LOCK_OPEN = 2'b11
   } swd_lock_e;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } swd_io_req_s;

endpackage

// >>> src/swd_tick.sv
// one-second tick generator of the watchdog timer
module swd_tick #(
   parameter int unsigned CYCLES = 50000000
) (
   input wire logic clk_in,      // system clock
   input wire logic nrst_in,     // async reset, active low
   input wire logic restart_in,  // restart the second from zero
   output logic tick_out         // one-cycle pulse per second
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt;

   // free-running divider, restarted so a unit is always whole
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= '0;
         tick_out <= 1'b0;
      end else if (restart_in) begin
         cnt <= '0;
         tick_out <= 1'b0;
      end else if (cnt == LAST) begin
         cnt <= '0;
         tick_out <= 1'b1;
      end else begin
         cnt <= cnt + W'(1);
         tick_out <= 1'b0;
      end
   end

endmodule

// >>> src/swd_top.sv
// super i/o watchdog timer behind the index/data configuration ports
// Notes on behaviour
// RULE1 - count down, request system reset at zero
// RULE2 - software reloads before the count runs out
// RULE3 - index port selects, data port reads/writes
// RULE4 - two key writes unlock configuration space
// RULE5 - logical device 08h selects the watchdog
// RULE6 - activate 01h enables, 00h disables anytime
// RULE7 - time base 00h seconds, 08h minutes
// RULE8 - timeout count holds 0 to 255
// RULE9 - M expires after M units, zero disables
// RULE10 - timeout write restarts countdown, one per unit
module swd_top #(
   parameter int unsigned CYCLES_PER_SECOND = swd_pkg::CYCLES_PER_SECOND
) (
   input wire logic CLK_IN,            // 50 MHz system clock
   input wire logic NRST_IN,           // async reset, active low
   input wire logic [15:0] IO_ADDR_IN, // host i/o port address
   input wire logic IO_WR_IN,          // one-cycle write strobe
   input wire logic IO_RD_IN,          // one-cycle read strobe
   input wire logic [7:0] IO_WDATA_IN, // write data
   output logic [7:0] IO_RDATA_OUT,    // read data, next cycle
   output logic SYS_RESET_OUT,         // system reset request level
   output logic WATCHDOG_ACTIVE_OUT    // countdown enabled
);

   // ****************************************************************
   // decode
   // ****************************************************************
   swd_pkg::swd_io_req_s req;
   swd_pkg::swd_lock_e lock;
   logic [7:0] index;
   logic [7:0] ldn;
   logic [7:0] activate;
   logic [7:0] time_base;
   logic [7:0] timeout;
   logic [7:0] count;
   logic [5:0] sec_in_min;
   logic sec_tick;
   logic unit_tick;
   logic idx_wr, data_wr, data_rd, open, sel;
   logic load, act_wr, running, minute;
   logic expire;

   assign req = '{addr: IO_ADDR_IN, wr: IO_WR_IN, rd: IO_RD_IN,
                  wdata: IO_WDATA_IN};
   assign open = (lock == swd_pkg::LOCK_OPEN);
   assign idx_wr = req.wr && (req.addr == swd_pkg::INDEX_PORT); // RULE3
   assign data_wr = req.wr && (req.addr == swd_pkg::DATA_PORT) && open;
   assign data_rd = req.rd && (req.addr == swd_pkg::DATA_PORT);
   assign sel = (ldn == swd_pkg::LDN_WATCHDOG_TIMER); // RULE5
   assign load = data_wr && sel && (index == swd_pkg::IDX_TIMEOUT_COUNT);
   assign act_wr = data_wr && sel &&
                   (index == swd_pkg::IDX_WATCHDOG_ACTIVATE);
   assign minute = time_base[swd_pkg::TIME_BASE_MINUTE_BIT]; // RULE7
   assign running = activate[swd_pkg::ACTIVATE_BIT] && (timeout != 8'h00)
                    && (count != 8'h00); // RULE9
   assign unit_tick = minute ?
      (sec_tick && (sec_in_min == swd_pkg::SECONDS_PER_MINUTE - 6'h01))
      : sec_tick; // RULE7
   // last unit of a running count, watched by the checks below
   assign expire = running && unit_tick && (count == 8'h01);
   assign WATCHDOG_ACTIVE_OUT = activate[swd_pkg::ACTIVATE_BIT];

   // ****************************************************************
   // unlock sequence: two key writes to the index port in a row
   // ****************************************************************
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         lock <= swd_pkg::LOCK_CLOSED;
      end else if (idx_wr && !open) begin
         if (req.wdata != swd_pkg::UNLOCK_KEY) begin
            lock <= swd_pkg::LOCK_CLOSED; // RULE4
         end else if (lock == swd_pkg::LOCK_ONE_KEY) begin
            lock <= swd_pkg::LOCK_OPEN; // RULE4
         end else begin
            lock <= swd_pkg::LOCK_ONE_KEY;
         end
      end
   end

   // index register, only once unlocked
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         index <= swd_pkg::INDEX_RESET;
      end else if (idx_wr && open) begin
         index <= req.wdata; // RULE3
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ldn <= swd_pkg::REG_RESET;
         activate <= swd_pkg::REG_RESET;
         time_base <= swd_pkg::REG_RESET;
         timeout <= swd_pkg::REG_RESET;
      end else if (data_wr) begin
         if (index == swd_pkg::IDX_LOGICAL_DEVICE_SELECT) begin
            ldn <= req.wdata; // RULE5
         end else if (sel && index == swd_pkg::IDX_WATCHDOG_ACTIVATE) begin
            activate <= req.wdata; // RULE6
         end else if (sel && index == swd_pkg::IDX_TIME_BASE_SELECT) begin
            time_base <= req.wdata; // RULE7
         end else if (sel && index == swd_pkg::IDX_TIMEOUT_COUNT) begin
            timeout <= req.wdata; // RULE8
         end
      end
   end

   // read data: selected register, all ones while locked
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         IO_RDATA_OUT <= swd_pkg::LOCKED_READ;
      end else if (data_rd && open) begin
         if (index == swd_pkg::IDX_LOGICAL_DEVICE_SELECT) begin
            IO_RDATA_OUT <= ldn;
         end else if (sel && index == swd_pkg::IDX_WATCHDOG_ACTIVATE) begin
            IO_RDATA_OUT <= activate;
         end else if (sel && index == swd_pkg::IDX_TIME_BASE_SELECT) begin
            IO_RDATA_OUT <= time_base;
         end else if (sel && index == swd_pkg::IDX_TIMEOUT_COUNT) begin
            IO_RDATA_OUT <= count; // live remaining count
         end else begin
            IO_RDATA_OUT <= swd_pkg::LOCKED_READ;
         end
      end else if (req.rd && open && req.addr == swd_pkg::INDEX_PORT) begin
         IO_RDATA_OUT <= index;
      end else if (req.rd) begin
         IO_RDATA_OUT <= swd_pkg::LOCKED_READ;
      end
   end

   // ****************************************************************
   // time base
   // ****************************************************************
   swd_tick #(
      .CYCLES(CYCLES_PER_SECOND)
   ) u_tick (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .restart_in(load || act_wr), // RULE10
      .tick_out(sec_tick)
   );

   // seconds within the current minute
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sec_in_min <= 6'h00;
      end else if (load || act_wr) begin
         sec_in_min <= 6'h00;
      end else if (sec_tick) begin
         if (sec_in_min == swd_pkg::SECONDS_PER_MINUTE - 6'h01) begin
            sec_in_min <= 6'h00;
         end else begin
            sec_in_min <= sec_in_min + 6'h01;
         end
      end
   end

   // ****************************************************************
   // countdown and reset request
   // ****************************************************************
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         count <= swd_pkg::REG_RESET;
      end else if (load) begin
         count <= req.wdata; // RULE10
      end else if (act_wr) begin
         count <= timeout; // re-arm from the stored value
      end else if (running && unit_tick) begin
         count <= count - 8'h01; // RULE1
      end
   end

   // expiry wins over a reload arriving in the same cycle
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         SYS_RESET_OUT <= 1'b0;
      end else if (running && unit_tick && count == 8'h01) begin
         SYS_RESET_OUT <= 1'b1; // RULE1
      end else if (load || act_wr) begin
         SYS_RESET_OUT <= 1'b0; // RULE2
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);

   // one key write on the index port
   sequence s_key_write;
      idx_wr && req.wdata == swd_pkg::UNLOCK_KEY;
   endsequence

   // two key writes with one idle cycle between them
   sequence s_key_twice;
      s_key_write ##1 !idx_wr ##1 s_key_write;
   endsequence

   a_unlock_keys: assert property ( // RULE4
      $rose(open) |-> $past(idx_wr && req.wdata == swd_pkg::UNLOCK_KEY))
      else $error("unlocked without key write");
   a_unlock_open: assert property (!open ##0 s_key_twice |=> open) // RULE4
      else $error("two keys did not unlock");
   a_locked_ignore: assert property ( // RULE3
      !open && req.wr |=> $stable(activate) && $stable(timeout))
      else $error("write accepted while locked");
   a_ldn_gate: assert property ( // RULE5
      data_wr && !sel |=> $stable(activate) && $stable(time_base))
      else $error("watchdog register written without device select");
   a_load_restart: assert property ( // RULE10
      load |=> count == $past(req.wdata) &&
      (!SYS_RESET_OUT || $past(expire)))
      else $error("timeout write did not restart countdown");
   a_count_step: assert property ( // RULE10
      running && unit_tick && !load && !act_wr
      |=> count == $past(count) - 8'h01)
      else $error("count did not step once per unit");
   a_expire_reset: assert property ( // RULE1
      expire |=> SYS_RESET_OUT ##1
      (SYS_RESET_OUT || $past(load || act_wr)))
      else $error("reset request missing at zero");
   a_zero_off: assert property ( // RULE9
      timeout == 8'h00 && !SYS_RESET_OUT && !load && !act_wr
      |=> !SYS_RESET_OUT)
      else $error("zero timeout expired");
   a_disable: assert property ( // RULE6
      act_wr && req.wdata == swd_pkg::ACTIVATE_OFF
      |=> !WATCHDOG_ACTIVE_OUT ##1 $stable(count))
      else $error("disable not honoured");
   a_minute_base: assert property ( // RULE7
      minute && sec_tick &&
      sec_in_min != swd_pkg::SECONDS_PER_MINUTE - 6'h01 |-> !unit_tick)
      else $error("minute base stepped early");

endmodule

// >>> tb/swd_top_tb.sv
// self-checking bench of the super i/o watchdog timer
module swd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPS = 10;
   logic CLK_IN = 1'b0;
   logic NRST_IN = 1'b0;
   logic [15:0] IO_ADDR_IN = 16'h0000;
   logic IO_WR_IN = 1'b0;
   logic IO_RD_IN = 1'b0;
   logic [7:0] IO_WDATA_IN = 8'h00;
   logic [7:0] IO_RDATA_OUT;
   logic SYS_RESET_OUT;
   logic WATCHDOG_ACTIVE_OUT;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h00000036;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;

   swd_top #(.CYCLES_PER_SECOND(CPS)) u_swd_top (
      .CLK_IN(CLK_IN),
      .NRST_IN(NRST_IN),
      .IO_ADDR_IN(IO_ADDR_IN),
      .IO_WR_IN(IO_WR_IN),
      .IO_RD_IN(IO_RD_IN),
      .IO_WDATA_IN(IO_WDATA_IN),
      .IO_RDATA_OUT(IO_RDATA_OUT),
      .SYS_RESET_OUT(SYS_RESET_OUT),
      .WATCHDOG_ACTIVE_OUT(WATCHDOG_ACTIVE_OUT)
   );

   // ************************************************
   // clock, timeout and reporting
   // ************************************************
   always #10 CLK_IN = ~CLK_IN;

   // cut a hang short
   always @(posedge CLK_IN) begin
      cycles++;
      if (cycles == 12000) begin
         errors++;
         $display("Error: run_length expected below 12000 seen 12000");
         final_report();
      end
   end

   task automatic final_report;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error: %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   // ************************************************
   // host port drivers
   // ************************************************
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CLK_IN);
      #1;
      IO_ADDR_IN = a;
      IO_WDATA_IN = d;
      IO_WR_IN = 1'b1;
      @(posedge CLK_IN);
      #1;
      IO_WR_IN = 1'b0;
   endtask

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      io_wr(swd_pkg::INDEX_PORT, idx);
      io_wr(swd_pkg::DATA_PORT, d);
   endtask

   // read one port, noting the expected byte first
   task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      @(posedge CLK_IN);
      #1;
      IO_ADDR_IN = a;
      IO_RD_IN = 1'b1;
      @(posedge CLK_IN);
      #1;
      IO_RD_IN = 1'b0;
      @(posedge CLK_IN);
   endtask

   // read one register through the index/data pair
   task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
      io_wr(swd_pkg::INDEX_PORT, idx);
      io_rd(swd_pkg::DATA_PORT, exp);
   endtask

   // wait, then compare the reset request level
   task automatic expect_rst(input int n, input logic exp);
      repeat (n) @(posedge CLK_IN);
      #1;
      check("sys_reset", {7'h00, SYS_RESET_OUT}, {7'h00, exp});
   endtask

   // ************************************************
   // read data watcher: oldest note against the bus
   // ************************************************
   always @(posedge CLK_IN) rd_seen <= IO_RD_IN;
   always @(negedge CLK_IN) begin
      if (rd_seen) begin
         check("read_data", IO_RDATA_OUT, exp_q.pop_front());
      end
   end

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      logic [7:0] rv;
      repeat (20) @(posedge CLK_IN);
      #1;
      NRST_IN = 1'b1;
      check("active", {7'h00, WATCHDOG_ACTIVE_OUT}, 8'h00);
      // locked space, broken key pair
      io_rd(swd_pkg::INDEX_PORT, 8'hff);
      reg_rd(swd_pkg::IDX_LOGICAL_DEVICE_SELECT, 8'hff);
      io_wr(swd_pkg::INDEX_PORT, swd_pkg::UNLOCK_KEY);
      io_wr(swd_pkg::INDEX_PORT, 8'h00);
      io_wr(swd_pkg::INDEX_PORT, swd_pkg::UNLOCK_KEY);
      reg_rd(swd_pkg::IDX_LOGICAL_DEVICE_SELECT, 8'hff);
      io_wr(swd_pkg::INDEX_PORT, swd_pkg::UNLOCK_KEY);
      io_wr(swd_pkg::INDEX_PORT, swd_pkg::UNLOCK_KEY);
      $display("test unlock done");
      // wrong logical device hides the watchdog registers
      reg_wr(swd_pkg::IDX_LOGICAL_DEVICE_SELECT, 8'h05);
      reg_rd(swd_pkg::IDX_LOGICAL_DEVICE_SELECT, 8'h05);
      reg_rd(swd_pkg::IDX_WATCHDOG_ACTIVATE, 8'hff);
      reg_wr(swd_pkg::IDX_LOGICAL_DEVICE_SELECT, 8'h08);
      reg_rd(swd_pkg::IDX_WATCHDOG_ACTIVATE, 8'h00);
      reg_rd(8'h20, 8'hff);
      io_rd(swd_pkg::INDEX_PORT, 8'h20);
      // random time base bytes read back
      for (int i = 0; i < 4; i++) begin
         seed = xorshift(seed);
         rv = seed[7:0];
         reg_wr(swd_pkg::IDX_TIME_BASE_SELECT, rv);
         reg_rd(swd_pkg::IDX_TIME_BASE_SELECT, rv);
      end
      reg_wr(swd_pkg::IDX_TIME_BASE_SELECT, 8'h00);
      $display("test select done");
      // expiry after three seconds
      reg_wr(swd_pkg::IDX_WATCHDOG_ACTIVATE, 8'h01);
      check("active", {7'h00, WATCHDOG_ACTIVE_OUT}, 8'h01);
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h03);
      expect_rst(3 * CPS - 3, 1'b0);
      expect_rst(5, 1'b1);
      reg_rd(swd_pkg::IDX_TIMEOUT_COUNT, 8'h00);
      $display("test expiry done");
      // periodic reloads keep the request away
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h03);
      expect_rst(1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         expect_rst(2 * CPS, 1'b0);
         reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h03);
      end
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h01);
      expect_rst(CPS - 3, 1'b0);
      expect_rst(5, 1'b1);
      $display("test reload done");
      // zero count never expires
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h00);
      expect_rst(30 * CPS, 1'b0);
      // disable in mid count
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h02);
      expect_rst(CPS, 1'b0);
      reg_wr(swd_pkg::IDX_WATCHDOG_ACTIVATE, 8'h00);
      check("active", {7'h00, WATCHDOG_ACTIVE_OUT}, 8'h00);
      expect_rst(4 * CPS, 1'b0);
      $display("test disable done");
      // one minute unit
      reg_wr(swd_pkg::IDX_TIME_BASE_SELECT, swd_pkg::TIME_BASE_MINUTE);
      reg_wr(swd_pkg::IDX_WATCHDOG_ACTIVATE, 8'h01);
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'h01);
      expect_rst(60 * CPS - 3, 1'b0);
      expect_rst(5, 1'b1);
      $display("test minute done");
      // largest count in seconds
      reg_wr(swd_pkg::IDX_TIME_BASE_SELECT, swd_pkg::TIME_BASE_SECOND);
      reg_wr(swd_pkg::IDX_TIMEOUT_COUNT, 8'hff);
      expect_rst(255 * CPS - 3, 1'b0);
      expect_rst(5, 1'b1);
      $display("test full count done");
      final_report();
   end
endmodule
